/* hw/pin_irq_pkg.sv */
package pin_irq_pkg;
    localparam int CHANNELS = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] OFS_MODE_SELECT = 12'h000;
    localparam logic [11:0] OFS_RL_ENABLE = 12'h004;
    localparam logic [11:0] OFS_RL_SET = 12'h008;
    localparam logic [11:0] OFS_RL_CLEAR = 12'h00c;
    localparam logic [11:0] OFS_FAL = 12'h010;
    localparam logic [11:0] OFS_FAL_SET = 12'h014;
    localparam logic [11:0] OFS_FAL_CLEAR = 12'h018;
    localparam logic [11:0] OFS_RISE_FLAGS = 12'h01c;
    localparam logic [11:0] OFS_FALL_FLAGS = 12'h020;
    localparam logic [11:0] OFS_STATUS = 12'h024;
    localparam logic [11:0] OFS_PM_CONTROL = 12'h028;
    localparam logic [11:0] OFS_PM_SOURCE = 12'h02c;
    localparam logic [11:0] OFS_PM_CONFIG = 12'h030;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h040;
    localparam logic [11:0] OFS_EVT_CLEAR = 12'h044;
    localparam logic [11:0] OFS_EVT_ENABLE = 12'h048;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int CHAN_LSB = 0;
    localparam int CHAN_MSB = 7;
    localparam logic [7:0] CHAN_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam int EVT_W = 2;
    localparam int EVT_BAD_ADDR = 0;
    localparam int EVT_RL_CHANGE = 1;
    localparam logic [1:0] EVT_RESET = 2'h0;
    localparam logic MODE_EDGE = 1'b0;
    localparam logic MODE_LEVEL = 1'b1;
endpackage

/* hw/pin_irq_mode_enable_regs.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R01 - there are eight channels, each with one bit choosing edge or level sensing.
// R02 - the mode register holds the mode bits in 7:0, 0 meaning edge and 1 meaning level.
// R03 - in edge mode the rise-or-level enable bit enables rising edge interrupts.
// R04 - in level mode the rise-or-level enable bit enables the level interrupt.
// R05 - in level mode the fall-or-active-level bit gives the active polarity.
// R06 - the rise-or-level enable register keeps eight read/write bits reset to 0.
// R07 - writing ones to offset 0x008 sets the matching enable bits, zeros leave them.
// R08 - mode sits at 0x000 and rise-or-level enable at 0x004, both read/write reset 0.
// R09 - a write-only clear port for the enable bits sits at 0x00c.
// R10 - fall-or-active-level is read/write at 0x010 with set and clear ports at 0x014, 0x018.
// R11 - rising flags at 0x01c, falling flags at 0x020 and status at 0x024 are read/write reset 0.
// R12 - pattern control 0x028, slice source 0x02c, slice config 0x030, read/write reset 0.
// R13 - writing ones to the enable-clear port clears the matching enable bits.
// R14 - a fall-or-active-level bit of 0 means falling disabled or active low, 1 the opposite.
// R15 - write-only ports and reserved bits 31:8 read as zero and ignore writes.
module pin_irq_mode_enable_regs
    import pin_irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [pin_irq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pin_irq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pin_irq_pkg::DATA_W-1:0] reg_rdata,
    output logic [pin_irq_pkg::CHANNELS-1:0] channel_mode_bits,
    output logic [pin_irq_pkg::CHANNELS-1:0] rise_level_enable_bits,
    output logic [pin_irq_pkg::CHANNELS-1:0] fall_active_level_bits,
    output logic [pin_irq_pkg::CHANNELS-1:0] rise_edge_enable,
    output logic [pin_irq_pkg::CHANNELS-1:0] fall_edge_enable,
    output logic [pin_irq_pkg::CHANNELS-1:0] level_enable,
    output logic [pin_irq_pkg::CHANNELS-1:0] level_active_high,
    output logic [pin_irq_pkg::DATA_W-1:0] rising_flags_word,
    output logic [pin_irq_pkg::DATA_W-1:0] falling_flags_word,
    output logic [pin_irq_pkg::DATA_W-1:0] status_word,
    output logic [pin_irq_pkg::DATA_W-1:0] pm_control_word,
    output logic [pin_irq_pkg::DATA_W-1:0] pm_source_word,
    output logic [pin_irq_pkg::DATA_W-1:0] pm_config_word,
    output logic irq
);
    import pin_irq_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [CHANNELS-1:0] mode;
        logic [CHANNELS-1:0] rl_en;
        logic [CHANNELS-1:0] fal;
        logic [DATA_W-1:0] rise_flags;
        logic [DATA_W-1:0] fall_flags;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] pm_ctrl;
        logic [DATA_W-1:0] pm_src;
        logic [DATA_W-1:0] pm_cfg;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] evt_en;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // byte address to a known-register hit
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_MODE_SELECT, OFS_RL_ENABLE, OFS_RL_SET, OFS_RL_CLEAR,
            OFS_FAL, OFS_FAL_SET, OFS_FAL_CLEAR, OFS_RISE_FLAGS,
            OFS_FALL_FLAGS, OFS_STATUS, OFS_PM_CONTROL, OFS_PM_SOURCE,
            OFS_PM_CONFIG, OFS_EVT_STATUS, OFS_EVT_CLEAR, OFS_EVT_ENABLE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // zero-extend a channel vector to a bus word
    function automatic logic [DATA_W-1:0] chan_word(input logic [CHANNELS-1:0] v);
        chan_word = WORD_RESET;
        chan_word[CHAN_MSB:CHAN_LSB] = v;
    endfunction

    logic [CHANNELS-1:0] wbits;
    logic [EVT_W-1:0] evt_hit;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        wbits = reg_wdata[CHAN_MSB:CHAN_LSB]; // [R15]
        evt_hit = EVT_RESET;
        state_nxt.rdata = WORD_RESET;
        if (reg_write) begin
            case (reg_addr)
                OFS_MODE_SELECT: state_nxt.mode = wbits; // [R02] [R08]
                OFS_RL_ENABLE: state_nxt.rl_en = wbits; // [R06] [R08]
                OFS_RL_SET: state_nxt.rl_en = state_r.rl_en | wbits; // [R07]
                OFS_RL_CLEAR: state_nxt.rl_en = state_r.rl_en & ~wbits; // [R09] [R13]
                OFS_FAL: state_nxt.fal = wbits; // [R10] [R14]
                OFS_FAL_SET: state_nxt.fal = state_r.fal | wbits; // [R10]
                OFS_FAL_CLEAR: state_nxt.fal = state_r.fal & ~wbits; // [R10]
                OFS_RISE_FLAGS: state_nxt.rise_flags = chan_word(wbits); // [R11]
                OFS_FALL_FLAGS: state_nxt.fall_flags = chan_word(wbits); // [R11]
                OFS_STATUS: state_nxt.status = chan_word(wbits); // [R11]
                // pattern engine words are kept whole; their fields live elsewhere
                OFS_PM_CONTROL: state_nxt.pm_ctrl = reg_wdata; // [R12]
                OFS_PM_SOURCE: state_nxt.pm_src = reg_wdata; // [R12]
                OFS_PM_CONFIG: state_nxt.pm_cfg = reg_wdata; // [R12]
                OFS_EVT_ENABLE: state_nxt.evt_en = reg_wdata[EVT_W-1:0];
                default: ;
            endcase
            if (state_nxt.rl_en != state_r.rl_en) begin
                evt_hit[EVT_RL_CHANGE] = 1'b1;
            end
        end
        if ((reg_write || reg_read) && !is_mapped(reg_addr)) begin
            evt_hit[EVT_BAD_ADDR] = 1'b1;
        end
        // clear first, then set, so a same-cycle event survives
        if (reg_write && reg_addr == OFS_EVT_CLEAR) begin
            state_nxt.evt = state_r.evt & ~reg_wdata[EVT_W-1:0];
        end
        state_nxt.evt = state_nxt.evt | evt_hit;
        if (reg_read) begin
            case (reg_addr)
                OFS_MODE_SELECT: state_nxt.rdata = chan_word(state_r.mode);
                OFS_RL_ENABLE: state_nxt.rdata = chan_word(state_r.rl_en);
                OFS_FAL: state_nxt.rdata = chan_word(state_r.fal);
                OFS_RISE_FLAGS: state_nxt.rdata = state_r.rise_flags;
                OFS_FALL_FLAGS: state_nxt.rdata = state_r.fall_flags;
                OFS_STATUS: state_nxt.rdata = state_r.status;
                OFS_PM_CONTROL: state_nxt.rdata = state_r.pm_ctrl;
                OFS_PM_SOURCE: state_nxt.rdata = state_r.pm_src;
                OFS_PM_CONFIG: state_nxt.rdata = state_r.pm_cfg;
                OFS_EVT_STATUS: state_nxt.rdata = {30'h0000_0000, state_r.evt};
                OFS_EVT_ENABLE: state_nxt.rdata = {30'h0000_0000, state_r.evt_en};
                default: state_nxt.rdata = WORD_RESET; // [R15]
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata = state_r.rdata;
    assign channel_mode_bits = state_r.mode; // [R01]
    assign rise_level_enable_bits = state_r.rl_en;
    assign fall_active_level_bits = state_r.fal;
    assign rise_edge_enable = state_r.rl_en & ~state_r.mode; // [R03]
    assign fall_edge_enable = state_r.fal & ~state_r.mode; // [R14]
    assign level_enable = state_r.rl_en & state_r.mode; // [R04]
    assign level_active_high = state_r.fal & state_r.mode; // [R05]
    assign rising_flags_word = state_r.rise_flags;
    assign falling_flags_word = state_r.fall_flags;
    assign status_word = state_r.status;
    assign pm_control_word = state_r.pm_ctrl;
    assign pm_source_word = state_r.pm_src;
    assign pm_config_word = state_r.pm_cfg;
    assign irq = |(state_r.evt & state_r.evt_en);

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_set_write;
        reg_write && reg_addr == OFS_RL_SET;
    endsequence

    sequence s_clear_write;
        reg_write && reg_addr == OFS_RL_CLEAR;
    endsequence

    property p_set_bits;
        @(posedge clk_sys) disable iff (!reset_n)
        s_set_write |=> (rise_level_enable_bits == ($past(rise_level_enable_bits)
            | $past(reg_wdata[7:0])));
    endproperty
    a_set_bits: assert property (p_set_bits) else $error("enable set failed"); // [R07]

    property p_clear_bits;
        @(posedge clk_sys) disable iff (!reset_n)
        s_clear_write |=> (rise_level_enable_bits == ($past(rise_level_enable_bits)
            & ~$past(reg_wdata[7:0])));
    endproperty
    a_clear_bits: assert property (p_clear_bits) else $error("enable clear failed"); // [R13]

    property p_enable_rw;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_RL_ENABLE) ##1 (reg_read && reg_addr == OFS_RL_ENABLE
            && !reg_write) |=> (reg_rdata == {24'h000000, $past(reg_wdata[7:0], 2)});
    endproperty
    a_enable_rw: assert property (p_enable_rw) else $error("enable readback wrong"); // [R06]

    property p_mode_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_MODE_SELECT) |=>
            (channel_mode_bits == $past(reg_wdata[7:0]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // [R02]

    property p_rise_edge;
        @(posedge clk_sys) disable iff (!reset_n)
        rise_edge_enable == (rise_level_enable_bits & ~channel_mode_bits);
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising enable wrong"); // [R03]

    property p_level_en;
        @(posedge clk_sys) disable iff (!reset_n)
        (level_enable & ~channel_mode_bits) == 8'h00;
    endproperty
    a_level_en: assert property (p_level_en) else $error("level enable in edge mode"); // [R04]

    property p_polarity;
        @(posedge clk_sys) disable iff (!reset_n)
        level_active_high == (fall_active_level_bits & channel_mode_bits);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong"); // [R05]

    property p_wo_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && (reg_addr == OFS_RL_SET || reg_addr == OFS_FAL_CLEAR))
            |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only port read nonzero"); // [R15]

    property p_fal_set;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_FAL_SET) |=>
            ((fall_active_level_bits & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]));
    endproperty
    a_fal_set: assert property (p_fal_set) else $error("fall set failed"); // [R10]

    // ************************************************************
    // checks on plain writes, reads and holding
    // ************************************************************
    property p_enable_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_RL_ENABLE) |=> (rise_level_enable_bits == $past(reg_wdata[7:0]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // [R06]

    property p_fal_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_FAL) |=> (fall_active_level_bits == $past(reg_wdata[7:0]));
    endproperty
    a_fal_write: assert property (p_fal_write) else $error("fall write lost"); // [R10]

    property p_fal_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_FAL_CLEAR) |=> (fall_active_level_bits
            == ($past(fall_active_level_bits) & ~$past(reg_wdata[7:0])));
    endproperty
    a_fal_clear: assert property (p_fal_clear) else $error("fall clear failed"); // [R10]

    property p_fal_set_keep;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_FAL_SET) |=> (fall_active_level_bits
            == ($past(fall_active_level_bits) | $past(reg_wdata[7:0])));
    endproperty
    a_fal_set_keep: assert property (p_fal_set_keep) else $error("fall set lost bits"); // [R10]

    property p_rise_flag_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_RISE_FLAGS) |=>
            (rising_flags_word == {24'h000000, $past(reg_wdata[7:0])});
    endproperty
    a_rise_flag_write: assert property (p_rise_flag_write) else $error("rise flags wrong"); // [R11]

    property p_fall_flag_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_FALL_FLAGS) |=>
            (falling_flags_word == {24'h000000, $past(reg_wdata[7:0])});
    endproperty
    a_fall_flag_write: assert property (p_fall_flag_write) else $error("fall flags wrong"); // [R11]

    property p_status_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_STATUS) |=>
            (status_word == {24'h000000, $past(reg_wdata[7:0])});
    endproperty
    a_status_write: assert property (p_status_write) else $error("status write wrong"); // [R11]

    property p_pm_ctrl_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_PM_CONTROL) |=> (pm_control_word == $past(reg_wdata));
    endproperty
    a_pm_ctrl_write: assert property (p_pm_ctrl_write) else $error("pattern control lost"); // [R12]

    property p_pm_src_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_PM_SOURCE) |=> (pm_source_word == $past(reg_wdata));
    endproperty
    a_pm_src_write: assert property (p_pm_src_write) else $error("slice source lost"); // [R12]

    property p_pm_cfg_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && reg_addr == OFS_PM_CONFIG) |=> (pm_config_word == $past(reg_wdata));
    endproperty
    a_pm_cfg_write: assert property (p_pm_cfg_write) else $error("slice config lost"); // [R12]

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        (rising_flags_word[31:8] | falling_flags_word[31:8] | status_word[31:8]) == 24'h000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [R15]

    property p_mode_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && reg_addr == OFS_MODE_SELECT && !reg_write) |=>
            (reg_rdata == {24'h000000, $past(channel_mode_bits)});
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong"); // [R08]

    property p_enable_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && reg_addr == OFS_RL_ENABLE && !reg_write) |=>
            (reg_rdata == {24'h000000, $past(rise_level_enable_bits)});
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable read wrong"); // [R08]

    property p_fal_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && reg_addr == OFS_FAL && !reg_write) |=>
            (reg_rdata == {24'h000000, $past(fall_active_level_bits)});
    endproperty
    a_fal_read: assert property (p_fal_read) else $error("fall readback wrong"); // [R10]

    // read data stand for one cycle only, so a stale word never looks fresh
    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        !reg_read |=> (reg_rdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingered");

    property p_clear_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && (reg_addr == OFS_RL_CLEAR || reg_addr == OFS_FAL_SET))
            |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("write-only read nonzero"); // [R15]

    property p_mode_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        !(reg_write && reg_addr == OFS_MODE_SELECT) |=> $stable(channel_mode_bits);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked"); // [R02]

    property p_enable_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        !(reg_write && (reg_addr == OFS_RL_ENABLE || reg_addr == OFS_RL_SET
            || reg_addr == OFS_RL_CLEAR)) |=> $stable(rise_level_enable_bits);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable changed unasked"); // [R06]

    property p_fal_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        !(reg_write && (reg_addr == OFS_FAL || reg_addr == OFS_FAL_SET
            || reg_addr == OFS_FAL_CLEAR)) |=> $stable(fall_active_level_bits);
    endproperty
    a_fal_hold: assert property (p_fal_hold) else $error("fall bits changed unasked"); // [R14]

    property p_fall_edge;
        @(posedge clk_sys) disable iff (!reset_n)
        fall_edge_enable == (fall_active_level_bits & ~channel_mode_bits);
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling enable wrong"); // [R14]

    property p_level_split;
        @(posedge clk_sys) disable iff (!reset_n)
        (level_enable | rise_edge_enable) == rise_level_enable_bits;
    endproperty
    a_level_split: assert property (p_level_split) else $error("enable split wrong"); // [R04]

    // an unmapped read must raise its bad-address event in the next cycle
    property p_bad_addr_evt;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && !is_mapped(reg_addr)) |=> state_r.evt[EVT_BAD_ADDR];
    endproperty
    a_bad_addr_evt: assert property (p_bad_addr_evt) else $error("unmapped event lost");

    property p_unmapped_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && !is_mapped(reg_addr)) |=> ($stable(channel_mode_bits)
            && $stable(rise_level_enable_bits) && $stable(fall_active_level_bits));
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write landed"); // [R15]
endmodule

/* dv/cpu_bus_model.sv */
`timescale 1ns/1ps
// ************************************************************
// processor side of the register port
// ************************************************************
module cpu_bus_model
    import pin_irq_pkg::*;
(
    input wire logic clk_sys,
    output logic [pin_irq_pkg::ADDR_W-1:0] reg_addr,
    output logic [pin_irq_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [pin_irq_pkg::DATA_W-1:0] reg_rdata
);
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // idle write data is inverted so the block cannot lean on a stale word
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // write followed by a read with no idle cycle between the two strobes
    task automatic wr_then_rd(input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        q = reg_rdata;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* dv/pin_irq_mode_enable_regs_tb.sv */
`timescale 1ns/1ps
// ************************************************************
// register front end bench
// ************************************************************
module pin_irq_mode_enable_regs_tb;
    import pin_irq_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rise_w, fall_w, stat_w, pmc_w, pms_w, pmg_w;
    logic reg_write, reg_read, irq;
    logic [7:0] mode_b, en_b, fal_b, re_en, fe_en, lv_en, lv_hi;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    cpu_bus_model i_cpu (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    pin_irq_mode_enable_regs i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .channel_mode_bits(mode_b),
        .rise_level_enable_bits(en_b), .fall_active_level_bits(fal_b),
        .rise_edge_enable(re_en), .fall_edge_enable(fe_en), .level_enable(lv_en),
        .level_active_high(lv_hi), .rising_flags_word(rise_w), .falling_flags_word(fall_w),
        .status_word(stat_w), .pm_control_word(pmc_w), .pm_source_word(pms_w),
        .pm_config_word(pmg_w), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_cpu.rd(a, d);
        chk(d, exp);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // mapped words only: an unmapped read would already raise an event
    task automatic t_reset();
        chk({irq, mode_b, en_b, fal_b}, 32'h0);
        for (int i = 0; i <= 12; i++) begin
            rchk(12'(i * 4), 32'h0);
        end
        rchk(OFS_EVT_STATUS, 32'h0);
    endtask
    task automatic t_modes();
        logic [31:0] d;
        i_cpu.wr(OFS_MODE_SELECT, 32'hffff_ffa5);
        i_cpu.wr_then_rd(OFS_RL_ENABLE, 32'h0000_ff3c, d);
        chk(d, 32'h0000_003c);
        i_cpu.wr(OFS_FAL, 32'h1234_560f);
        rchk(OFS_MODE_SELECT, 32'h0000_00a5);
        rchk(OFS_RL_ENABLE, 32'h0000_003c);
        rchk(OFS_FAL, 32'h0000_000f);
        chk(mode_b, 8'ha5);
        chk(re_en, 8'h18);
        chk(lv_en, 8'h24);
        chk(lv_hi, 8'h05);
        chk(fe_en, 8'h0a);
    endtask
    task automatic t_setclr();
        i_cpu.wr(OFS_RL_SET, 32'hffff_ff81);
        chk(en_b, 8'hbd);
        i_cpu.wr(OFS_RL_CLEAR, 32'hffff_ff0c);
        chk(en_b, 8'hb1);
        i_cpu.wr(OFS_FAL_SET, 32'h0000_00f0);
        i_cpu.wr(OFS_FAL_CLEAR, 32'h0000_0011);
        chk(fal_b, 8'hee);
        rchk(OFS_RL_SET, 32'h0);
        rchk(OFS_RL_CLEAR, 32'h0);
        rchk(OFS_FAL_CLEAR, 32'h0);
    endtask
    task automatic t_plain();
        i_cpu.wr(OFS_RISE_FLAGS, 32'hffff_ff5a);
        i_cpu.wr(OFS_FALL_FLAGS, 32'h0000_01a5);
        i_cpu.wr(OFS_STATUS, 32'h8000_0033);
        i_cpu.wr(OFS_PM_CONTROL, 32'h1357_9bdf);
        i_cpu.wr(OFS_PM_SOURCE, 32'h2468_ace0);
        i_cpu.wr(OFS_PM_CONFIG, 32'hfedc_ba98);
        rchk(OFS_RISE_FLAGS, 32'h0000_005a);
        rchk(OFS_FALL_FLAGS, 32'h0000_00a5);
        rchk(OFS_STATUS, 32'h0000_0033);
        rchk(OFS_PM_CONTROL, 32'h1357_9bdf);
        rchk(OFS_PM_SOURCE, 32'h2468_ace0);
        rchk(OFS_PM_CONFIG, 32'hfedc_ba98);
        chk(fall_w, 32'h0000_00a5);
        chk(pms_w, 32'h2468_ace0);
        chk(rise_w, 32'h0000_005a);
        chk(stat_w, 32'h0000_0033);
        chk(pmc_w, 32'h1357_9bdf);
        chk(pmg_w, 32'hfedc_ba98);
    endtask
    // raise and clear both interrupt events, masking only the bad-address one
    task automatic t_irq();
        i_cpu.wr(OFS_EVT_ENABLE, 32'h0000_0003);
        i_cpu.wr(OFS_EVT_CLEAR, 32'h0000_0003);
        chk(irq, 1'b0);
        rchk(12'h100, 32'h0);
        chk(irq, 1'b1);
        rchk(OFS_EVT_STATUS, 32'h0000_0001);
        i_cpu.wr(OFS_EVT_ENABLE, 32'h0000_0002);
        chk(irq, 1'b0);
        i_cpu.wr(OFS_EVT_CLEAR, 32'h0000_0001);
        i_cpu.wr(OFS_RL_SET, 32'h0000_0002);
        chk(irq, 1'b1);
        chk(en_b, 8'hb3);
        rchk(OFS_EVT_STATUS, 32'h0000_0002);
        i_cpu.wr(OFS_EVT_CLEAR, 32'h0000_0002);
        chk(irq, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_modes();
        t_setclr();
        t_plain();
        t_irq();
        print_verdict();
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
